// ### sbpc_pkg.sv
// Shared constants for the sequential buffer pointer and command control block
package sbpc_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int RDATA_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_WR = 6;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
    localparam logic [ADDR_W-1:0] DATA_ZERO = 13'h0000;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] PTR_RST = 13'h0000;
    localparam logic [ADDR_W-1:0] B1_START_RST = 13'h0000;
    localparam logic [ADDR_W-1:0] B1_END_RST = 13'h0fff;
    localparam logic [ADDR_W-1:0] B2_START_RST = 13'h1000;
    localparam logic [ADDR_W-1:0] B2_END_RST = 13'h1fff;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [SEL_W-1:0] CMD_B1_START = 3'h0;
    localparam logic [SEL_W-1:0] CMD_B1_END = 3'h1;
    localparam logic [SEL_W-1:0] CMD_B2_START = 3'h2;
    localparam logic [SEL_W-1:0] CMD_B2_END = 3'h3;
    localparam logic [SEL_W-1:0] CMD_FLOW = 3'h4;
    localparam logic [SEL_W-1:0] CMD_FLAGS = 3'h5;

    // ****************************************
    // Flow control and flag status fields
    // ****************************************
    localparam logic [1:0] FLOW_CHAIN = 2'h0;
    localparam logic [1:0] FLOW_STOP = 2'h1;
    localparam logic [1:0] FLOW_LINEAR = 2'h2;
    localparam logic [1:0] FLOW_MASK = 2'h3;
    localparam logic [3:0] FLOW_RST = 4'h0;
    localparam int FC_B1_LO = 0;
    localparam int FC_B2_LO = 2;
    localparam int FC_MODE_W = 4;
    localparam int FC_STOP_BIT = 4;
    localparam int FS_B1_BIT = 0;
    localparam int FS_B2_BIT = 1;

    // ****************************************
    // Pointer sequencer states
    // ****************************************
    typedef enum logic {PTR_RUN, PTR_LOAD_WAIT} sbpc_ptr_state_t;
endpackage

// ### sbpc_cmd_dec.sv
// Command mode decoder for the random-port register accesses
`timescale 1ns/1ps
module sbpc_cmd_dec
    import sbpc_pkg::*;
(
    // Random port controls
    input wire logic cmd_select_n_i,
    input wire logic rand_chip_enable_n_i,
    input wire logic rand_read_write_i,
    input wire logic [SEL_W-1:0] sel_i,
    // Decoded strobes
    output logic [NUM_WR-1:0] wr_o,
    output logic rd_o
);
    logic active;

    assign active = !cmd_select_n_i && rand_chip_enable_n_i;
    assign rd_o = active && rand_read_write_i;

    // Codes 110 and 111 get no write strobe; a read there still raises rd_o
    for (genvar i = 0; i < NUM_WR; i++) begin : g_wr
        assign wr_o[i] = active && !rand_read_write_i && (sel_i == SEL_W'(i));
    end
endmodule // sbpc_cmd_dec

// ### sbpc_top.sv
// Sequential address pointer and buffer command registers
`timescale 1ns/1ps
// How it works
// - Load high, jump1 low, jump2 high: pointer takes buffer 1 start.
// - Load high, jump1 high, jump2 low: pointer takes buffer 2 start.
// - Load low at an edge captures thirteen sequential data lines into holding.
// - Holding register moves into the pointer on the next edge.
// - Count enable ignored and no increment during load and following cycle.
// - A start jump completes in one clock cycle.
// - Jump data ready at next edge; pin load one edge later.
// - Pointer loads ignore chip enable, count enable and read/write.
// - Low reset reinitialises control state at once, without a clock.
// - Reset: pointer zero, flags high, chaining, deselected, write direction.
// - Reset bounds: buffer 1 0..4095, buffer 2 4096..8191.
// - Command mode uses three low address bits and data lines 0-12.
// - Codes 000 and 010 write or read the start addresses.
// - Codes 001 and 011 write or read the end addresses.
// - Code 100 writes or reads the flow control register.
// - Write at code 101 clears buffer 1 and/or buffer 2 end flag.
// - Read at code 101 returns flag status.
// - Pointer also changes at a buffer end per its flow mode.
// - Chaining: end sets that flag and jumps to other buffer start.
module sbpc_top
    import sbpc_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // Sequential port
    input wire logic POINTER_LOAD_N_I,
    input wire logic START1_JUMP_N_I,
    input wire logic START2_JUMP_N_I,
    input wire logic COUNT_ENABLE_N_I,
    input wire logic SEQ_CHIP_ENABLE_N_I,
    input wire logic SEQ_READ_WRITE_I,
    input wire logic [ADDR_W-1:0] SEQ_DATA_LINES_I,
    // Random port command access
    input wire logic CMD_SELECT_N_I,
    input wire logic RAND_CHIP_ENABLE_N_I,
    input wire logic RAND_READ_WRITE_I,
    input wire logic [SEL_W-1:0] COMMAND_SELECT_BITS_I,
    input wire logic [RDATA_W-1:0] RANDOM_DATA_LINES_I,
    // Pointer and flags
    output logic [ADDR_W-1:0] ADDR_POINTER_O,
    output logic BUF1_END_FLAG_N_O,
    output logic BUF2_END_FLAG_N_O,
    output logic SEQ_CE_REG_N_O,
    output logic SEQ_RW_REG_O,
    // Command read data
    output logic [ADDR_W-1:0] RANDOM_DATA_LINES_O,
    output logic RANDOM_DATA_OE_O
);
    // ****************************************
    // Command decode
    // ****************************************
    logic [NUM_WR-1:0] wr;
    logic rd;
    logic [ADDR_W-1:0] wdata;

    sbpc_cmd_dec u_dec (
        .cmd_select_n_i(CMD_SELECT_N_I),
        .rand_chip_enable_n_i(RAND_CHIP_ENABLE_N_I),
        .rand_read_write_i(RAND_READ_WRITE_I),
        .sel_i(COMMAND_SELECT_BITS_I),
        .wr_o(wr),
        .rd_o(rd)
    );

    // Upper data lines never reach a register
    assign wdata = RANDOM_DATA_LINES_I[ADDR_W-1:0];

    // ****************************************
    // State
    // ****************************************
    sbpc_ptr_state_t state, next_state;
    logic [ADDR_W-1:0] ptr, next_ptr;
    logic [ADDR_W-1:0] hold, next_hold;
    logic [ADDR_W-1:0] b1_start, next_b1_start;
    logic [ADDR_W-1:0] b1_end, next_b1_end;
    logic [ADDR_W-1:0] b2_start, next_b2_start;
    logic [ADDR_W-1:0] b2_end, next_b2_end;
    logic [FC_MODE_W-1:0] flow, next_flow;
    logic stopped, next_stopped;
    logic st1, next_st1;
    logic st2, next_st2;
    logic flag1_n, next_flag1_n;
    logic flag2_n, next_flag2_n;
    logic ce_reg_n, next_ce_reg_n;
    logic rw_reg, next_rw_reg;
    logic [ADDR_W-1:0] rdata, next_rdata;
    logic rdata_oe, next_rdata_oe;

    logic [1:0] mode1, mode2;
    logic hit1, hit2, advance, set1, set2, stop_hit;

    assign mode1 = flow[FC_B1_LO +: 2];
    assign mode2 = flow[FC_B2_LO +: 2];
    assign hit1 = (ptr == b1_end);
    assign hit2 = (ptr == b2_end);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_state = state;
        next_ptr = ptr;
        next_hold = hold;
        next_stopped = stopped;
        advance = 1'b0;
        stop_hit = 1'b0;
        unique case (state)
            PTR_RUN: begin
                if (!POINTER_LOAD_N_I) begin
                    next_hold = SEQ_DATA_LINES_I;
                    next_state = PTR_LOAD_WAIT;
                end else if (!START1_JUMP_N_I && START2_JUMP_N_I) begin
                    next_ptr = b1_start;
                    next_stopped = 1'b0;
                end else if (START1_JUMP_N_I && !START2_JUMP_N_I) begin
                    next_ptr = b2_start;
                    next_stopped = 1'b0;
                end else if (!COUNT_ENABLE_N_I && !stopped) begin
                    advance = 1'b1;
                    next_ptr = ADDR_W'(ptr + ADDR_ONE);
                    // Chain to buffer 1 wins when both ends match
                    if (hit1 && mode1 == FLOW_CHAIN) begin
                        next_ptr = b2_start;
                    end
                    if (hit2 && mode2 == FLOW_CHAIN) begin
                        next_ptr = b1_start;
                    end
                    stop_hit = (hit1 && mode1 == FLOW_STOP) || (hit2 && mode2 == FLOW_STOP);
                end
            end
            PTR_LOAD_WAIT: begin
                // Jump inputs are held high here by the controller
                next_ptr = hold;
                next_stopped = 1'b0;
                next_state = PTR_RUN;
            end
        endcase
        if (wr[CMD_FLOW] && !wdata[FC_STOP_BIT]) begin
            next_stopped = 1'b0;
        end
        // A fresh stop beats a release in the same cycle
        if (stop_hit) begin
            next_stopped = 1'b1;
        end
    end

    // Flags, status and command registers
    always_comb begin
        set1 = advance && hit1;
        set2 = advance && hit2;
        next_b1_start = wr[CMD_B1_START] ? wdata : b1_start;
        next_b2_start = wr[CMD_B2_START] ? wdata : b2_start;
        next_b1_end = wr[CMD_B1_END] ? wdata : b1_end;
        next_b2_end = wr[CMD_B2_END] ? wdata : b2_end;
        next_flow = wr[CMD_FLOW] ? wdata[FC_MODE_W-1:0] : flow;
        next_st1 = st1;
        next_st2 = st2;
        if (wr[CMD_FLAGS] && wdata[FS_B1_BIT]) begin
            next_st1 = 1'b0;
        end
        if (wr[CMD_FLAGS] && wdata[FS_B2_BIT]) begin
            next_st2 = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (set1) begin
            next_st1 = 1'b1;
        end
        if (set2) begin
            next_st2 = 1'b1;
        end
        // Mask mode keeps status but hides the pin
        next_flag1_n = !(next_st1 && next_flow[FC_B1_LO +: 2] != FLOW_MASK);
        next_flag2_n = !(next_st2 && next_flow[FC_B2_LO +: 2] != FLOW_MASK);
        next_ce_reg_n = SEQ_CHIP_ENABLE_N_I;
        next_rw_reg = SEQ_READ_WRITE_I;
    end

    // Command read data, registered one edge after the request
    always_comb begin
        next_rdata = DATA_ZERO;
        next_rdata_oe = rd;
        if (rd) begin
            case (COMMAND_SELECT_BITS_I)
                CMD_B1_START: next_rdata = b1_start;
                CMD_B1_END: next_rdata = b1_end;
                CMD_B2_START: next_rdata = b2_start;
                CMD_B2_END: next_rdata = b2_end;
                CMD_FLOW: begin
                    next_rdata = DATA_ZERO;
                    next_rdata[FC_MODE_W-1:0] = flow;
                    next_rdata[FC_STOP_BIT] = stopped;
                end
                CMD_FLAGS: begin
                    next_rdata = DATA_ZERO;
                    next_rdata[FS_B1_BIT] = st1;
                    next_rdata[FS_B2_BIT] = st2;
                end
                default: next_rdata = DATA_ZERO;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Reset acts without the clock so control state clears at once
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= PTR_RUN;
            ptr <= PTR_RST;
            hold <= PTR_RST;
            b1_start <= B1_START_RST;
            b1_end <= B1_END_RST;
            b2_start <= B2_START_RST;
            b2_end <= B2_END_RST;
            flow <= FLOW_RST;
            stopped <= 1'b0;
            st1 <= 1'b0;
            st2 <= 1'b0;
            flag1_n <= 1'b1;
            flag2_n <= 1'b1;
            ce_reg_n <= 1'b1;
            rw_reg <= 1'b0;
            rdata <= DATA_ZERO;
            rdata_oe <= 1'b0;
        end else begin
            state <= next_state;
            ptr <= next_ptr;
            hold <= next_hold;
            b1_start <= next_b1_start;
            b1_end <= next_b1_end;
            b2_start <= next_b2_start;
            b2_end <= next_b2_end;
            flow <= next_flow;
            stopped <= next_stopped;
            st1 <= next_st1;
            st2 <= next_st2;
            flag1_n <= next_flag1_n;
            flag2_n <= next_flag2_n;
            ce_reg_n <= next_ce_reg_n;
            rw_reg <= next_rw_reg;
            rdata <= next_rdata;
            rdata_oe <= next_rdata_oe;
        end
    end

    assign ADDR_POINTER_O = ptr;
    assign BUF1_END_FLAG_N_O = flag1_n;
    assign BUF2_END_FLAG_N_O = flag2_n;
    assign SEQ_CE_REG_N_O = ce_reg_n;
    assign SEQ_RW_REG_O = rw_reg;
    assign RANDOM_DATA_LINES_O = rdata;
    assign RANDOM_DATA_OE_O = rdata_oe;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    start1_load_a: assert property (
        (state == PTR_RUN && POINTER_LOAD_N_I && !START1_JUMP_N_I && START2_JUMP_N_I)
        |=> (ADDR_POINTER_O == $past(b1_start))) else $error("start 1 jump missed");
    start2_load_a: assert property (
        (state == PTR_RUN && POINTER_LOAD_N_I && START1_JUMP_N_I && !START2_JUMP_N_I)
        |=> (ADDR_POINTER_O == $past(b2_start))) else $error("start 2 jump missed");
    pin_load_a: assert property (
        (state == PTR_RUN && !POINTER_LOAD_N_I) ##1 POINTER_LOAD_N_I
        |=> (ADDR_POINTER_O == $past(SEQ_DATA_LINES_I, 2))) else $error("pin load late or wrong");
    load_hold_a: assert property (
        (state == PTR_RUN && !POINTER_LOAD_N_I) |=> $stable(ADDR_POINTER_O) && state == PTR_LOAD_WAIT)
        else $error("pointer moved during load");
    cmd_write_a: assert property (
        wr[CMD_B2_START] |=> (b2_start == $past(RANDOM_DATA_LINES_I[ADDR_W-1:0])))
        else $error("start 2 write lost");
    flag_clear_a: assert property (
        (wr[CMD_FLAGS] && wdata[FS_B1_BIT] && !set1) |=> BUF1_END_FLAG_N_O && !st1)
        else $error("buffer 1 flag not cleared");
    flag_read_a: assert property (
        (rd && COMMAND_SELECT_BITS_I == CMD_FLAGS)
        |=> RANDOM_DATA_OE_O && RANDOM_DATA_LINES_O[FS_B2_BIT] == $past(st2))
        else $error("flag status read wrong");
    chain_jump_a: assert property (
        (advance && hit1 && !hit2 && mode1 == FLOW_CHAIN)
        |=> (ADDR_POINTER_O == $past(b2_start)) && !BUF1_END_FLAG_N_O) else $error("chain jump failed");
    reserved_a: assert property (
        (!CMD_SELECT_N_I && RAND_CHIP_ENABLE_N_I && COMMAND_SELECT_BITS_I[2:1] == 2'h3)
        |=> $stable(b1_start) && $stable(b1_end) && $stable(b2_start) && $stable(b2_end) && $stable(flow)
        && (RANDOM_DATA_LINES_O == DATA_ZERO)) else $error("reserved code changed state");
endmodule // sbpc_top

// ### sbpc_host.sv
// Host controller model driving the sequential port and the command port
`timescale 1ns/1ps
module sbpc_host
    import sbpc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Sequential port
    output logic load_n_o,
    output logic jump1_n_o,
    output logic jump2_n_o,
    output logic count_n_o,
    output logic seq_ce_n_o,
    output logic seq_rw_o,
    output logic [ADDR_W-1:0] seq_data_o,
    // Command port
    output logic cmd_n_o,
    output logic rand_ce_n_o,
    output logic rand_rw_o,
    output logic [SEL_W-1:0] sel_o,
    output logic [RDATA_W-1:0] rdata_o
);
    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        {load_n_o, jump1_n_o, jump2_n_o, count_n_o, seq_ce_n_o, seq_rw_o} = 6'h3e;
        {cmd_n_o, rand_ce_n_o, rand_rw_o, sel_o} = 6'h38;
        seq_data_o = 13'h0aaa;
        rdata_o = 16'h5555;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic cyc();
        @(posedge clk_i);
        #1;
    endtask

    // Sequential level controls, one assignment each per call
    task automatic seq_ctl(input logic ce_n, input logic cnt_n, input logic rw);
        {seq_ce_n_o, count_n_o, seq_rw_o} = {ce_n, cnt_n, rw};
    endtask

    // Idle edge first, so two requests in a row never retoggle select in one step
    // Select low with chip enable high; released lines show the inverse
    task automatic cmd(input logic rw, input logic [SEL_W-1:0] s, input logic [RDATA_W-1:0] d);
        cyc();
        {cmd_n_o, rand_ce_n_o, rand_rw_o, sel_o, rdata_o} = {1'b0, 1'b1, rw, s, d};
        cyc();
        {cmd_n_o, rdata_o} = {1'b1, ~d};
    endtask

    // Left standing until the next request replaces it; back-to-back jumps are legal
    task automatic jump(input logic two);
        {jump1_n_o, jump2_n_o} = two ? 2'b10 : 2'b01;
        cyc();
    endtask

    // First edge only; jumps stay high across both load edges
    task automatic load_a(input logic [ADDR_W-1:0] d);
        {load_n_o, jump1_n_o, jump2_n_o, seq_data_o} = {3'b011, d};
        cyc();
        {load_n_o, seq_data_o} = {1'b1, ~d};
    endtask
endmodule // sbpc_host

// ### sbpc_top_tb_top.sv
// Self-checking bench for the pointer and command control block
`timescale 1ns/1ps
module sbpc_top_tb_top
    import sbpc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    logic load_n, j1_n, j2_n, cnt_n, sce_n, srw, cmd_n, rce_n, rrw, f1, f2, cer, rwr, oe;
    logic [ADDR_W-1:0] sdat, ptr, rdat;
    logic [SEL_W-1:0] sel;
    logic [RDATA_W-1:0] wdat;
    logic [15:0] wv [4] = '{16'he123, 16'h0456, 16'h1789, 16'h1abc};

    always #5 clk = ~clk;

    sbpc_host i_sbpc_host (.clk_i(clk), .load_n_o(load_n), .jump1_n_o(j1_n), .jump2_n_o(j2_n),
        .count_n_o(cnt_n), .seq_ce_n_o(sce_n), .seq_rw_o(srw), .seq_data_o(sdat), .cmd_n_o(cmd_n),
        .rand_ce_n_o(rce_n), .rand_rw_o(rrw), .sel_o(sel), .rdata_o(wdat));

    sbpc_top i_sbpc_top (.CORE_CLK_I(clk), .NRST_I(nrst), .POINTER_LOAD_N_I(load_n),
        .START1_JUMP_N_I(j1_n), .START2_JUMP_N_I(j2_n), .COUNT_ENABLE_N_I(cnt_n),
        .SEQ_CHIP_ENABLE_N_I(sce_n), .SEQ_READ_WRITE_I(srw), .SEQ_DATA_LINES_I(sdat),
        .CMD_SELECT_N_I(cmd_n), .RAND_CHIP_ENABLE_N_I(rce_n), .RAND_READ_WRITE_I(rrw),
        .COMMAND_SELECT_BITS_I(sel), .RANDOM_DATA_LINES_I(wdat), .ADDR_POINTER_O(ptr),
        .BUF1_END_FLAG_N_O(f1), .BUF2_END_FLAG_N_O(f2), .SEQ_CE_REG_N_O(cer), .SEQ_RW_REG_O(rwr),
        .RANDOM_DATA_LINES_O(rdat), .RANDOM_DATA_OE_O(oe));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd(input logic [SEL_W-1:0] s, input logic [15:0] e, input string nm);
        i_sbpc_host.cmd(1'b1, s, 16'h0000);
        chk(nm, {3'h0, rdat}, e);
        chk("read enable", {15'h0, oe}, 16'h0001);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk("pointer", {3'h0, ptr}, 16'h0000);
        chk("flags", {14'h0, f1, f2}, 16'h0003);
        chk("seq state", {14'h0, cer, rwr}, 16'h0002);
        rd(CMD_B1_START, 16'h0000, "b1 start");
        rd(CMD_B1_END, 16'h0fff, "b1 end");
        rd(CMD_B2_START, 16'h1000, "b2 start");
        rd(CMD_B2_END, 16'h1fff, "b2 end");
        rd(CMD_FLOW, 16'h0000, "flow");
    endtask

    // Upper data bits set on purpose; reserved writes must not disturb anything
    task automatic t_cmd();
        for (int i = 0; i < 4; i++) begin
            i_sbpc_host.cmd(1'b0, 3'(i), wv[i]);
        end
        i_sbpc_host.cmd(1'b0, CMD_FLOW, 16'he00a);
        i_sbpc_host.cmd(1'b0, 3'h6, 16'h1555);
        i_sbpc_host.cmd(1'b0, 3'h7, 16'h1555);
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), wv[i] & 16'h1fff, "bound");
        end
        rd(CMD_FLOW, 16'h000a, "flow");
        rd(3'h6, 16'h0000, "reserved 6");
        rd(3'h7, 16'h0000, "reserved 7");
        i_sbpc_host.cmd(1'b0, CMD_FLOW, 16'h0000);
    endtask

    // Chip enable and count enable active must not disturb the jumps
    task automatic t_jump();
        i_sbpc_host.seq_ctl(1'b0, 1'b0, 1'b1);
        i_sbpc_host.jump(1'b0);
        chk("jump1", {3'h0, ptr}, 16'h0123);
        i_sbpc_host.jump(1'b1);
        chk("jump2", {3'h0, ptr}, 16'h1789);
        chk("ce state", {14'h0, cer, rwr}, 16'h0001);
        // Count left on for the load scenario
        i_sbpc_host.seq_ctl(1'b1, 1'b0, 1'b0);
    endtask

    // Load the b1 end address so the first counted edge chains
    task automatic t_load();
        i_sbpc_host.load_a(13'h0456);
        chk("edge a", {3'h0, ptr}, 16'h1789);
        i_sbpc_host.cyc();
        chk("edge b", {3'h0, ptr}, 16'h0456);
        i_sbpc_host.cyc();
        i_sbpc_host.seq_ctl(1'b1, 1'b1, 1'b0);
        chk("chain", {3'h0, ptr}, 16'h1789);
        chk("flags", {14'h0, f1, f2}, 16'h0001);
        rd(CMD_FLAGS, 16'h0001, "status");
        i_sbpc_host.cmd(1'b0, CMD_FLAGS, 16'h0001);
        chk("cleared", {14'h0, f1, f2}, 16'h0003);
        rd(CMD_FLAGS, 16'h0000, "status");
    endtask

    // Stop on buffer 2 end, then mask keeps the status but frees the pin
    task automatic t_flow();
        i_sbpc_host.cmd(1'b0, CMD_B2_END, 16'h178a);
        i_sbpc_host.cmd(1'b0, CMD_FLOW, 16'h0004);
        i_sbpc_host.seq_ctl(1'b1, 1'b0, 1'b0);
        repeat (3) i_sbpc_host.cyc();
        i_sbpc_host.seq_ctl(1'b1, 1'b1, 1'b0);
        chk("stop", {3'h0, ptr}, 16'h178b);
        chk("flags", {14'h0, f1, f2}, 16'h0002);
        rd(CMD_FLOW, 16'h0014, "stopped");
        i_sbpc_host.cmd(1'b0, CMD_FLOW, 16'h000c);
        chk("masked", {14'h0, f1, f2}, 16'h0003);
        rd(CMD_FLAGS, 16'h0002, "status");
        i_sbpc_host.seq_ctl(1'b1, 1'b0, 1'b0);
        i_sbpc_host.cyc();
        i_sbpc_host.seq_ctl(1'b1, 1'b1, 1'b0);
        chk("released", {3'h0, ptr}, 16'h178c);
    endtask

    task automatic t_areset();
        i_sbpc_host.cyc();
        nrst = 1'b0;
        #1;
        chk("async pointer", {3'h0, ptr}, 16'h0000);
        i_sbpc_host.cyc();
        nrst = 1'b1;
        i_sbpc_host.cyc();
        rd(CMD_B1_END, 16'h0fff, "b1 end");
        rd(CMD_B2_START, 16'h1000, "b2 start");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
        i_sbpc_host.cyc();
        t_reset();
        t_cmd();
        t_jump();
        t_load();
        t_flow();
        t_areset();
        stop_test();
    end

    // Whole run is under two hundred cycles
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule // sbpc_top_tb_top
